// ==== mmrl_pkg.sv ====
package mmrl_pkg;

  // Operation codes presented by the decoder with each execute strobe.
  typedef enum logic [3:0] {
    MMRL_OP_FAR_MOVE_TO_WORK       = 4'h0,
    MMRL_OP_FAR_MOVE_TO_MEM        = 4'h1,
    MMRL_OP_FAR_OR_TO_WORK         = 4'h2,
    MMRL_OP_FAR_OR_TO_MEM          = 4'h3,
    MMRL_OP_FAR_ROTL               = 4'h4,
    MMRL_OP_FAR_ROTL_TO_WORK       = 4'h5,
    MMRL_OP_FAR_ROTL_THRU_FLAG     = 4'h6,
    MMRL_OP_FAR_ROTL_THRU_FLAG_TO_WORK = 4'h7
  } mmrl_op_t;

  // Sequencer states: wait for a request, take the read data for one cycle, then write back if memory is the target.
  typedef enum logic [1:0] {
    MMRL_ST_IDLE  = 2'b00,
    MMRL_ST_READ  = 2'b01,
    MMRL_ST_WRITE = 2'b10
  } mmrl_state_t;

  localparam int          MMRL_DATA_W     = 8;
  localparam int          MMRL_ADDR_W     = 8;
  localparam logic [7:0]  MMRL_WORK_RST   = 8'h00;
  localparam logic        MMRL_FLAG_RST   = 1'b0;
  localparam int          MMRL_MSB        = 7;
  localparam logic [7:0]  MMRL_ZERO       = 8'h00;

endpackage

// ==== mmrl_alu.sv ====
`timescale 1ns/1ps

// Pure combinational result and flag former for the eight operations.
module mmrl_alu
  import mmrl_pkg::*;
(
  input  wire mmrl_op_t   op,
  input  wire logic [7:0] mem_val,
  input  wire logic [7:0] work_val,
  input  wire logic       shift_flag,
  output logic [7:0]      result,
  output logic            to_mem,
  output logic            to_work,
  output logic            null_upd,
  output logic            shift_upd,
  output logic            shift_new
);

  // The result is chosen per operation; all flag strobes default to idle.
  always_comb
  begin
    result    = mem_val;
    to_mem    = 1'b0;
    to_work   = 1'b0;
    null_upd  = 1'b0;
    shift_upd = 1'b0;
    shift_new = mem_val[MMRL_MSB];
    case (op)
      MMRL_OP_FAR_MOVE_TO_WORK:
      begin
        result  = mem_val;
        to_work = 1'b1;
      end
      MMRL_OP_FAR_MOVE_TO_MEM:
      begin
        result = work_val;
        to_mem = 1'b1;
      end
      MMRL_OP_FAR_OR_TO_WORK:
      begin
        result   = work_val | mem_val;
        to_work  = 1'b1;
        null_upd = 1'b1;
      end
      MMRL_OP_FAR_OR_TO_MEM:
      begin
        result   = mem_val | work_val;
        to_mem   = 1'b1;
        null_upd = 1'b1;
      end
      MMRL_OP_FAR_ROTL:
      begin
        result = {mem_val[6:0], mem_val[MMRL_MSB]};
        to_mem = 1'b1;
      end
      MMRL_OP_FAR_ROTL_TO_WORK:
      begin
        result  = {mem_val[6:0], mem_val[MMRL_MSB]};
        to_work = 1'b1;
      end
      MMRL_OP_FAR_ROTL_THRU_FLAG:
      begin
        result    = {mem_val[6:0], shift_flag};
        to_mem    = 1'b1;
        shift_upd = 1'b1;
      end
      MMRL_OP_FAR_ROTL_THRU_FLAG_TO_WORK:
      begin
        result    = {mem_val[6:0], shift_flag};
        to_work   = 1'b1;
        shift_upd = 1'b1;
      end
      default:
      begin
        // Unknown codes write nothing and change no flag.
        result = mem_val;
      end
    endcase
  end

endmodule

// ==== mmrl_exec.sv ====
// Notes on behaviour
// - Move memory to working register, flags untouched.
// - Move working register to memory, flags untouched.
// - OR into working register, update null flag.
// - OR into memory, update null flag.
// - Rotate memory left, bit 7 wraps, no flags.
// - Rotate left into working register, memory kept.
// - Rotate memory left through shift-out flag.
// - Same rotate through flag, result to working register.
`timescale 1ns/1ps

// One instruction runs as a short fixed sequence of clock cycles.
//   Cycle 0: the start strobe is taken while idle; op and address are captured.
//   Cycle 1: the read strobe and address are out; the operand comes back on
//            the read data bus in the same cycle and the result is formed.
//   Cycle 2: the working register and flags hold their new values; an op
//            that targets the working register raises done here.
//   Cycle 3: an op that targets memory raises done after its write strobe,
//            which stood in cycle 2.
// A strobe while busy is dropped without notice, so the decoder must wait
// for done before it asks again; done itself is a legal cycle to ask in.
// The memory must answer a read combinationally within the read cycle;
// a slower memory would need a wait state that this block does not have.

module mmrl_exec
  import mmrl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       exec_start,
  input  wire mmrl_op_t   exec_op,
  input  wire logic [7:0] exec_addr,
  input  wire logic [7:0] mem_rdata,
  output logic            exec_busy,
  output logic            exec_done,
  output logic            mem_rd,
  output logic            mem_wr,
  output logic [7:0]      mem_addr,
  output logic [7:0]      mem_wdata,
  output logic [7:0]      working_register,
  output logic            null_flag,
  output logic            shift_flag
);

  // Registered state; each _reg has its _next value computed below.
  mmrl_state_t state_reg;        // Sequencer state.
  mmrl_state_t state_next;       // Next sequencer state.
  mmrl_op_t    op_reg;           // Operation captured at the start strobe.
  mmrl_op_t    op_next;          // Next captured operation.
  logic        busy_reg;         // Request in progress.
  logic        busy_next;        // Next busy value.
  logic        done_reg;         // One-cycle completion pulse.
  logic        done_next;        // Next completion pulse.
  logic        rd_reg;           // Memory read strobe.
  logic        rd_next;          // Next read strobe.
  logic        wr_reg;           // Memory write strobe.
  logic        wr_next;          // Next write strobe.
  logic [7:0]  addr_reg;         // Captured operand address.
  logic [7:0]  addr_next;        // Next operand address.
  logic [7:0]  wdata_reg;        // Data driven with the write strobe.
  logic [7:0]  wdata_next;       // Next write data.
  logic [7:0]  work_reg;         // Working register.
  logic [7:0]  work_next;        // Next working register.
  logic        null_reg;         // Result-null flag.
  logic        null_next;        // Next result-null flag.
  logic        sflag_reg;        // Shift-out flag.
  logic        sflag_next;       // Next shift-out flag.

  // Combinational outputs of the ALU for the captured operation.
  logic [7:0]  alu_result;       // Result formed from the operand.
  logic        alu_to_mem;       // Result goes back to memory.
  logic        alu_to_work;      // Result goes to the working register.
  logic        alu_null_upd;     // Operation touches the null flag.
  logic        alu_shift_upd;    // Operation touches the shift-out flag.
  logic        alu_shift_new;    // New shift-out value, old bit 7.

  // The ALU works on the memory byte as it returns and on the old flags,
  // so a through-flag rotate sees the flag from before this instruction.
  mmrl_alu u_alu
  (
    .op         (op_reg),
    .mem_val    (mem_rdata),
    .work_val   (work_reg),
    .shift_flag (sflag_reg),
    .result     (alu_result),
    .to_mem     (alu_to_mem),
    .to_work    (alu_to_work),
    .null_upd   (alu_null_upd),
    .shift_upd  (alu_shift_upd),
    .shift_new  (alu_shift_new)
  );

  // Sequencer: a start strobe issues a read, the read data is used the
  // next cycle, and a write back follows only when memory is the target.
  // The move to memory also reads first; that keeps one fixed sequence at
  // the cost of one wasted memory read.
  always_comb
  begin
    // Everything holds unless a state below changes it.
    state_next = state_reg;
    op_next    = op_reg;
    busy_next  = busy_reg;
    // Strobes default low so that each one is a single-cycle pulse.
    done_next  = 1'b0;
    rd_next    = 1'b0;
    wr_next    = 1'b0;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    work_next  = work_reg;
    null_next  = null_reg;
    sflag_next = sflag_reg;
    case (state_reg)
      MMRL_ST_IDLE:
      begin
        // A strobe while busy cannot happen here; idle is the only taker.
        if (exec_start)
        begin
          // Capture op and address now; the decoder may change them after this edge.
          op_next    = exec_op;
          addr_next  = exec_addr;
          busy_next  = 1'b1;
          rd_next    = 1'b1;
          state_next = MMRL_ST_READ;
        end
      end
      MMRL_ST_READ:
      begin
        // Read data is valid in the same cycle as the read strobe.
        // Working-register targets take the result at this edge.
        if (alu_to_work)
        begin
          work_next = alu_result;
        end
        // Only the OR operations touch the null flag.
        if (alu_null_upd)
        begin
          null_next = (alu_result == MMRL_ZERO);
        end
        // Only the through-flag rotates touch the shift-out flag.
        if (alu_shift_upd)
        begin
          sflag_next = alu_shift_new;
        end
        // Memory targets need a write cycle; the others finish now.
        if (alu_to_mem)
        begin
          wr_next    = 1'b1;
          wdata_next = alu_result;
          state_next = MMRL_ST_WRITE;
        end
        else
        begin
          // Nothing to write back, so done comes one cycle earlier.
          busy_next  = 1'b0;
          done_next  = 1'b1;
          state_next = MMRL_ST_IDLE;
        end
      end
      MMRL_ST_WRITE:
      begin
        // Write strobe is out this cycle; finish.
        busy_next  = 1'b0;
        done_next  = 1'b1;
        state_next = MMRL_ST_IDLE;
      end
      default:
      begin
        // Unused code; recover to idle rather than hang busy.
        busy_next  = 1'b0;
        state_next = MMRL_ST_IDLE;
      end
    endcase
  end

  // Register stage; synchronous active-low reset.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      // Reset clears strobes, state and the visible registers alike.
      state_reg <= MMRL_ST_IDLE;
      op_reg    <= MMRL_OP_FAR_MOVE_TO_WORK;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      addr_reg  <= MMRL_ZERO;
      wdata_reg <= MMRL_ZERO;
      work_reg  <= MMRL_WORK_RST;
      null_reg  <= MMRL_FLAG_RST;
      sflag_reg <= MMRL_FLAG_RST;
    end
    else
    begin
      // Normal operation registers every next value.
      state_reg <= state_next;
      op_reg    <= op_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      work_reg  <= work_next;
      null_reg  <= null_next;
      sflag_reg <= sflag_next;
    end
  end

  // Every output is a flip-flop, so the decoder and memory see clean,
  // glitch-free strobes; the price is one cycle of latency on each, which
  // is why the read strobe trails the start strobe by a cycle.
  assign exec_busy        = busy_reg;
  assign exec_done        = done_reg;
  assign mem_rd           = rd_reg;
  assign mem_wr           = wr_reg;
  assign mem_addr         = addr_reg;
  assign mem_wdata        = wdata_reg;
  assign working_register = work_reg;
  assign null_flag        = null_reg;
  assign shift_flag       = sflag_reg;

endmodule

// ==== mmrl_mem_model.sv ====
`timescale 1ns/1ps

// Data memory beside the exec block; read data is valid only while mem_rd is high.
module mmrl_mem_model
(
  input  wire logic       clock,
  input  wire logic       mem_rd,
  input  wire logic       mem_wr,
  input  wire logic [7:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  output logic [7:0]      mem_rdata
);
  logic [7:0] mem_q [256];  // Byte store, preloaded by the bench.
  logic [7:0] last_reg = 8'h00;  // Last byte read out.

  // Outside a read the bus shows the inverse of the last byte, so stale data cannot pass.
  assign mem_rdata = mem_rd ? mem_q[mem_addr] : ~last_reg;

  // Writes land at the edge that sees the strobe.
  always @(posedge clock)
  begin
    if (mem_rd)
      last_reg <= mem_q[mem_addr];
    if (mem_wr)
      mem_q[mem_addr] <= mem_wdata;
  end
endmodule

// ==== mmrl_exec_checker.sv ====
`timescale 1ns/1ps

// Ties results, flags and strobes to the request that caused them.
module mmrl_exec_checker
  import mmrl_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       exec_start,
  input wire mmrl_op_t   exec_op,
  input wire logic [7:0] exec_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic       exec_busy,
  input wire logic       exec_done,
  input wire logic       mem_rd,
  input wire logic       mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] working_register,
  input wire logic       null_flag,
  input wire logic       shift_flag
);
  logic go;  // A request that is really taken.
  assign go = exec_start && !exec_busy;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_read;
    go |=> mem_rd && mem_addr == $past(exec_addr);
  endproperty
  a_read: assert property (p_read) else $error("read strobe or address wrong");
  property p_busy;
    go |=> exec_busy && !exec_done;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised after start");
  property p_move_work;
    go && exec_op == MMRL_OP_FAR_MOVE_TO_WORK |=> ##1 exec_done
      && working_register == $past(mem_rdata) && $stable(null_flag) && $stable(shift_flag);
  endproperty
  a_move_work: assert property (p_move_work) else $error("move to work wrong");
  property p_move_mem;
    go && exec_op == MMRL_OP_FAR_MOVE_TO_MEM |=> ##1 mem_wr && mem_wdata == working_register
      && $stable(null_flag) && $stable(shift_flag);
  endproperty
  a_move_mem: assert property (p_move_mem) else $error("move to mem wrong");
  property p_or_work;
    go && exec_op == MMRL_OP_FAR_OR_TO_WORK |=> ##1 null_flag == (working_register == MMRL_ZERO)
      && working_register == ($past(mem_rdata) | $past(working_register, 2));
  endproperty
  a_or_work: assert property (p_or_work) else $error("or to work wrong");
  property p_or_mem;
    go && exec_op == MMRL_OP_FAR_OR_TO_MEM |=> ##1 mem_wr
      && mem_wdata == ($past(mem_rdata) | working_register)
      && null_flag == (mem_wdata == MMRL_ZERO) ##1 exec_done;
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("or to mem wrong");
  property p_rotl;
    go && exec_op == MMRL_OP_FAR_ROTL |=> ##1 mem_wr && $stable(null_flag)
      && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])};
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate to mem wrong");
  property p_rotl_work;
    go && exec_op == MMRL_OP_FAR_ROTL_TO_WORK |=> ##1 !mem_wr && $stable(shift_flag)
      && working_register == {$past(mem_rdata[6:0]), $past(mem_rdata[7])};
  endproperty
  a_rotl_work: assert property (p_rotl_work) else $error("rotate to work wrong");
  property p_thru_mem;
    go && exec_op == MMRL_OP_FAR_ROTL_THRU_FLAG |=> ##1 mem_wr && shift_flag == $past(mem_rdata[7])
      && mem_wdata == {$past(mem_rdata[6:0]), $past(shift_flag, 2)};
  endproperty
  a_thru_mem: assert property (p_thru_mem) else $error("flag rotate to mem wrong");
  property p_thru_work;
    go && exec_op == MMRL_OP_FAR_ROTL_THRU_FLAG_TO_WORK |=> ##1 shift_flag == $past(mem_rdata[7])
      && working_register == {$past(mem_rdata[6:0]), $past(shift_flag, 2)};
  endproperty
  a_thru_work: assert property (p_thru_work) else $error("flag rotate to work wrong");
endmodule

// ==== memory_move_or_rotate_left_exec_tb.sv ====
`timescale 1ns/1ps

// Drives each operation against the memory model and checks results and flags.
module memory_move_or_rotate_left_exec_tb;
  import mmrl_pkg::*;
  logic       clock, rst_n, exec_start, exec_busy, exec_done, mem_rd, mem_wr;
  logic       null_flag, shift_flag;
  mmrl_op_t   exec_op;
  logic [7:0] exec_addr, mem_rdata, mem_addr, mem_wdata, working_register;
  int         err_total = 0;  // Mismatches seen.
  int         n_tests = 0;    // Comparisons made.

  mmrl_exec dut (.*);
  mmrl_mem_model mem (.*);

  // Free-running 125 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Starts at a falling edge, so a call straight after done starts back to back.
  task exec(input mmrl_op_t op, input logic [7:0] a);
    int n;
    n = 0;
    exec_start = 1'b1;
    exec_op = op;
    exec_addr = a;
    @(negedge clock);
    exec_start = 1'b0;
    chk(exec_busy, 8'h01);
    while (exec_done !== 1'b1 && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    chk(n < 8, 8'h01);
    chk(exec_busy, 8'h00);
  endtask

  task t_move;
    mem.mem_q[8'h10] = 8'hA5;
    exec(MMRL_OP_FAR_MOVE_TO_WORK, 8'h10);
    chk(working_register, 8'hA5);
    exec(MMRL_OP_FAR_MOVE_TO_MEM, 8'h11);
    chk(mem.mem_q[8'h11], 8'hA5);
  endtask

  task t_or;
    mem.mem_q[8'h12] = 8'h5A;
    mem.mem_q[8'h13] = 8'h00;
    exec(MMRL_OP_FAR_OR_TO_WORK, 8'h12);
    chk({working_register, null_flag}, 9'h1FE);
    exec(MMRL_OP_FAR_MOVE_TO_WORK, 8'h13);
    exec(MMRL_OP_FAR_OR_TO_MEM, 8'h13);
    chk({mem.mem_q[8'h13], null_flag}, 9'h001);
  endtask

  task t_rot;
    mem.mem_q[8'h20] = 8'h81;
    mem.mem_q[8'h21] = 8'h80;
    exec(MMRL_OP_FAR_ROTL, 8'h20);
    chk({mem.mem_q[8'h20], null_flag}, 9'h007);
    exec(MMRL_OP_FAR_ROTL_TO_WORK, 8'h20);
    chk({working_register, mem.mem_q[8'h20]}, 16'h0603);
    exec(MMRL_OP_FAR_ROTL_THRU_FLAG, 8'h21);
    chk({mem.mem_q[8'h21], shift_flag}, 9'h001);
    exec(MMRL_OP_FAR_ROTL_THRU_FLAG_TO_WORK, 8'h21);
    chk({working_register, shift_flag, mem.mem_q[8'h21]}, 17'h00200);
  endtask

  // Start is held high into the busy cycle with a new op; the second strobe must be ignored.
  task t_refuse;
    mem.mem_q[8'h22] = 8'h01;
    exec_start = 1'b1;
    exec_op = MMRL_OP_FAR_ROTL;
    exec_addr = 8'h22;
    @(negedge clock);
    exec_op = MMRL_OP_FAR_MOVE_TO_WORK;
    exec_addr = 8'h10;
    @(negedge clock);
    exec_start = 1'b0;
    @(negedge clock);
    chk({exec_done, working_register, mem.mem_q[8'h22]}, 17'h10102);
    @(negedge clock);
    chk(exec_done, 8'h00);
  endtask

  task finish_test;
    $display("errors %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: reset, then every operation.
  initial
  begin
    rst_n = 1'b0;
    exec_start = 1'b0;
    exec_op = MMRL_OP_FAR_MOVE_TO_WORK;
    exec_addr = 8'h00;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    chk({exec_busy, exec_done, mem_rd, mem_wr, mem_addr, mem_wdata, working_register,
         null_flag, shift_flag}, 30'h00000000);
    t_move;
    t_or;
    t_rot;
    t_refuse;
    finish_test;
  end

  // Watchdog; the whole run needs well under a microsecond.
  initial
  begin
    #20000;
    err_total++;
    finish_test;
  end
endmodule

bind mmrl_exec mmrl_exec_checker u_chk (.*);
